/* File: hdl/fcss_pkg.sv */
package fcss_pkg;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [5:0] {
        ST_INIT    = 6'b000001,
        ST_CLEAR   = 6'b000010,
        ST_WAIT    = 6'b000100,
        ST_CONFIG  = 6'b001000,
        ST_STARTUP = 6'b010000,
        ST_OPER    = 6'b100000
    } fcss_state_t;

    // ************************************************************
    // Register map (byte offsets)
    // ************************************************************
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_LENGTH = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_COUNT = 4'hC;

    typedef struct packed {
        logic       syncStart;
        logic [2:0] ioDelay;
        logic [2:0] gsrDelay;
        logic [2:0] doneDelay;
        logic       skipClear;
    } fcss_ctrl_t;

    localparam fcss_ctrl_t CTRL_RESET = '{syncStart: 1'b1, ioDelay: 3'h0, gsrDelay: 3'h0,
                                          doneDelay: 3'h0, skipClear: 1'b0};
    localparam logic [23:0] LENGTH_RESET = 24'h000000;
    localparam logic [2:0] DELAY_MAX = 3'h4;

    // ************************************************************
    // Synchroniser lanes
    // ************************************************************
    localparam int SY_RDY = 0;
    localparam int SY_PRG = 1;
    localparam int SY_RST = 2;
    localparam int SY_DONE = 3;
    localparam int SY_CLK = 4;
    localparam int SY_DAT = 5;
    localparam int SY_MODE = 6;
    localparam int SY_W = 10;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int INIT_DELAY_NS = 1000;
    localparam int INIT_DELAY_CYC = (INIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] RDY_SLAVE_CYC = 4'h2;
    localparam logic [3:0] RDY_MASTER_CYC = 4'h8;
    localparam int CFG_CLOCK_HALF_CYC = 4;
    localparam int MODE_MASTER_BIT = 0;
    localparam logic [7:0] END_WORD = 8'hFF;

endpackage

/* File: hdl/fpga_config_state_sequencer.sv */
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps

module fpga_config_state_sequencer #(
    parameter int MEM_AW = 6,
    parameter int INIT_CYC = fcss_pkg::INIT_DELAY_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    input wire logic setupReadyIn,
    output logic setupReadyOut,
    output logic setupReadyOe,
    input wire logic doneIn,
    output logic doneOut,
    output logic doneOe,
    input wire logic reprogram_request_n,
    input wire logic resetRequest_n,
    input wire logic [3:0] modePins,
    input wire logic cfg_clock_in,
    output logic cfg_clock_out,
    output logic cfg_clock_oe,
    input wire logic cfgData,
    output logic high_during_load,
    output logic low_during_load_n,
    output logic [2:0] ioConfigMode,
    output logic userIoTristate,
    output logic cellSetResetHold,
    output logic internal_bidir_buffer_tristate
);
    import fcss_pkg::*;

    localparam int MEM_DEPTH = 1 << MEM_AW;
    localparam int RDY_S = 1;
    localparam int RDY_M = 7;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [SY_W-1:0] syncA_reg;
    logic [SY_W-1:0] syncB_reg;
    logic clkPrev_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_reg <= '1;
            syncB_reg <= '1;
            // Matches the synchroniser reset level, so no false edge after reset
            clkPrev_reg <= 1'b1;
        end else begin
            syncA_reg <= {modePins, cfgData, cfg_clock_in, doneIn, resetRequest_n,
                          reprogram_request_n, setupReadyIn};
            syncB_reg <= syncA_reg;
            clkPrev_reg <= syncB_reg[SY_CLK];
        end
    end

    logic rdyS, prgS, rstS, doneS;
    logic [3:0] modeS;
    assign rdyS = syncB_reg[SY_RDY];
    assign prgS = syncB_reg[SY_PRG];
    assign rstS = syncB_reg[SY_RST];
    assign doneS = syncB_reg[SY_DONE];
    assign modeS = syncB_reg[SY_MODE +: 4];

    // ************************************************************
    // Registers and bus slave
    // ************************************************************
    fcss_ctrl_t ctrl_reg, ctrl_next;
    logic [23:0] length_reg, length_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    fcss_state_t state_reg, state_next;
    logic [23:0] cfgCount_reg, cfgCount_next;
    logic endSeen_reg, endSeen_next;
    logic [3:0] mode_reg, mode_next;
    logic doneRel_reg, doneRel_next;
    logic gsrRel_reg, gsrRel_next;
    logic ioAct_reg, ioAct_next;

    assign avsWaitrequest = (avsRead | avsWrite) & ~ack_reg;
    assign avsReaddata = rdata_reg;

    always_comb begin
        logic [31:0] merged;
        merged = {21'h0, ctrl_reg};
        ack_next = (avsRead | avsWrite) & ~ack_reg;
        ctrl_next = ctrl_reg;
        length_next = length_reg;
        rdata_next = rdata_reg;
        for (int b = 0; b < 4; b++) begin
            if (avsByteenable[b]) begin
                merged[b*8 +: 8] = avsWritedata[b*8 +: 8];
            end
        end
        if (avsWrite && ack_reg) begin
            unique case (avsAddress)
                OFS_CTRL: ctrl_next = fcss_ctrl_t'(merged[10:0]);
                OFS_LENGTH: begin
                    for (int b = 0; b < 3; b++) begin
                        if (avsByteenable[b]) begin
                            length_next[b*8 +: 8] = avsWritedata[b*8 +: 8];
                        end
                    end
                end
                default: ;
            endcase
        end
        if (avsRead && !ack_reg) begin
            unique case (avsAddress)
                OFS_CTRL: rdata_next = {21'h0, ctrl_reg};
                OFS_LENGTH: rdata_next = {8'h00, length_reg};
                OFS_STATUS: rdata_next = {16'h0, mode_reg, doneS, ioAct_reg, gsrRel_reg, doneRel_reg,
                                          2'h0, state_reg};
                OFS_COUNT: rdata_next = {8'h00, cfgCount_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
            length_reg <= LENGTH_RESET;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            length_reg <= length_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************************
    // Configuration clock
    // ************************************************************
    logic [2:0] div_reg, div_next;
    logic cfg_clock_reg, cfg_clock_next;
    logic master, cfgRise;
    assign master = mode_reg[MODE_MASTER_BIT];

    always_comb begin
        div_next = div_reg;
        cfg_clock_next = cfg_clock_reg;
        if (master && (state_reg == ST_CONFIG || state_reg == ST_STARTUP)) begin
            div_next = div_reg + 3'h1;
            if (div_reg == 3'(CFG_CLOCK_HALF_CYC - 1)) begin
                div_next = 3'h0;
                cfg_clock_next = ~cfg_clock_reg;
            end
        end else begin
            div_next = 3'h0;
            cfg_clock_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 3'h0;
            cfg_clock_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            cfg_clock_reg <= cfg_clock_next;
        end
    end

    // Slave finds edges of the external clock
    assign cfgRise = master ? (cfg_clock_next & ~cfg_clock_reg) : (syncB_reg[SY_CLK] & ~clkPrev_reg);
    assign cfg_clock_out = cfg_clock_reg;
    assign cfg_clock_oe = master & (state_reg == ST_CONFIG || state_reg == ST_STARTUP);

    // ************************************************************
    // Sequencer
    // ************************************************************
    logic [15:0] tmr_reg, tmr_next;
    logic [3:0] rdyCnt_reg, rdyCnt_next;
    logic [2:0] bitCnt_reg, bitCnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [MEM_AW-1:0] addr_reg, addr_next;
    logic once_reg, once_next;
    logic [2:0] stCnt_reg, stCnt_next;
    logic [2:0] dCnt_reg, dCnt_next;
    logic [2:0] ioMode_reg, ioMode_next;
    logic memWe;
    logic [7:0] memWdata;
    logic [7:0] cfgMem [MEM_DEPTH];

    function automatic logic [2:0] clampDelay(input logic [2:0] d);
        return (d > DELAY_MAX) ? DELAY_MAX : d;
    endfunction

    always_comb begin
        logic [7:0] word;
        logic [3:0] need;
        logic [2:0] base;
        word = {shift_reg[6:0], syncB_reg[SY_DAT]};
        need = modeS[MODE_MASTER_BIT] ? RDY_MASTER_CYC : RDY_SLAVE_CYC;
        base = ctrl_reg.syncStart ? dCnt_reg : stCnt_reg;
        state_next = state_reg;
        tmr_next = tmr_reg;
        rdyCnt_next = rdyCnt_reg;
        cfgCount_next = cfgCount_reg;
        endSeen_next = endSeen_reg;
        mode_next = mode_reg;
        bitCnt_next = bitCnt_reg;
        shift_next = shift_reg;
        addr_next = addr_reg;
        once_next = once_reg;
        stCnt_next = stCnt_reg;
        dCnt_next = dCnt_reg;
        doneRel_next = doneRel_reg;
        gsrRel_next = gsrRel_reg;
        ioAct_next = ioAct_reg;
        ioMode_next = ioMode_reg;
        memWe = 1'b0;
        memWdata = 8'h00;
        unique case (state_reg)
            ST_INIT: begin
                ioMode_next = modeS[2:0];
                tmr_next = tmr_reg + 16'h1;
                addr_next = '0;
                if (tmr_reg >= 16'(INIT_CYC - 1)) begin
                    state_next = (once_reg && ctrl_reg.skipClear) ? ST_WAIT : ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                memWe = 1'b1;
                addr_next = addr_reg + 1'b1;
                if (addr_reg == MEM_AW'(MEM_DEPTH - 1)) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Held here while line low or an abort input low
                rdyCnt_next = (rdyS && prgS && rstS) ? rdyCnt_reg + 4'h1 : 4'h0;
                // Sample mode and go; master waits longer
                if (rdyS && prgS && rstS && rdyCnt_reg == need - 4'h1) begin
                    state_next = ST_CONFIG;
                    mode_next = modeS;
                    cfgCount_next = 24'h0;
                    endSeen_next = 1'b0;
                    bitCnt_next = 3'h0;
                    addr_next = '0;
                    rdyCnt_next = 4'h0;
                end
            end
            ST_CONFIG: begin
                if (cfgRise) begin
                    cfgCount_next = cfgCount_reg + 24'h1;
                    shift_next = word;
                    bitCnt_next = bitCnt_reg + 3'h1;
                    if (bitCnt_reg == 3'h7) begin
                        memWe = 1'b1;
                        memWdata = word;
                        addr_next = addr_reg + 1'b1;
                        if (word == END_WORD) begin
                            endSeen_next = 1'b1;
                        end
                    end
                end
                // Length and end frame both needed
                if (cfgCount_reg == length_reg && endSeen_reg) begin
                    state_next = ST_STARTUP;
                    once_next = 1'b1;
                    stCnt_next = 3'h0;
                    dCnt_next = 3'h0;
                end
            end
            ST_STARTUP: begin
                if (cfgRise && stCnt_reg != 3'h7) begin
                    stCnt_next = stCnt_reg + 3'h1;
                end
                if (cfgRise && doneS && doneRel_reg && dCnt_reg != 3'h7) begin
                    dCnt_next = dCnt_reg + 3'h1;
                end
                // Each event on its own delay
                if (stCnt_reg >= clampDelay(ctrl_reg.doneDelay)) begin
                    doneRel_next = 1'b1;
                end
                // Sync mode counts from DONE high
                if ((!ctrl_reg.syncStart || doneS) && base >= clampDelay(ctrl_reg.gsrDelay)) begin
                    gsrRel_next = 1'b1;
                end
                if ((!ctrl_reg.syncStart || doneS) && base >= clampDelay(ctrl_reg.ioDelay)) begin
                    ioAct_next = 1'b1;
                end
                if (doneRel_reg && gsrRel_reg && ioAct_reg) begin
                    state_next = ST_OPER;
                end
            end
            ST_OPER: ;
        endcase
        if (state_reg == ST_CONFIG && (!prgS || !rstS)) begin
            state_next = ST_INIT;
        end
        // Only reprogram restarts a loaded device
        if ((state_reg == ST_STARTUP || state_reg == ST_OPER) && !prgS) begin
            state_next = ST_INIT;
        end
        if (state_next == ST_INIT && state_reg != ST_INIT) begin
            tmr_next = 16'h0;
            doneRel_next = 1'b0;
            gsrRel_next = 1'b0;
            ioAct_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_INIT;
            tmr_reg <= 16'h0;
            rdyCnt_reg <= 4'h0;
            cfgCount_reg <= 24'h0;
            endSeen_reg <= 1'b0;
            mode_reg <= 4'h0;
            bitCnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            addr_reg <= '0;
            once_reg <= 1'b0;
            stCnt_reg <= 3'h0;
            dCnt_reg <= 3'h0;
            doneRel_reg <= 1'b0;
            gsrRel_reg <= 1'b0;
            ioAct_reg <= 1'b0;
            ioMode_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            rdyCnt_reg <= rdyCnt_next;
            cfgCount_reg <= cfgCount_next;
            endSeen_reg <= endSeen_next;
            mode_reg <= mode_next;
            bitCnt_reg <= bitCnt_next;
            shift_reg <= shift_next;
            addr_reg <= addr_next;
            once_reg <= once_next;
            stCnt_reg <= stCnt_next;
            dCnt_reg <= dCnt_next;
            doneRel_reg <= doneRel_next;
            gsrRel_reg <= gsrRel_next;
            ioAct_reg <= ioAct_next;
            ioMode_reg <= ioMode_next;
        end
    end

    // No reset on the array; clearing is a sequenced walk
    always_ff @(posedge clk) begin
        if (memWe) begin
            cfgMem[addr_reg] <= memWdata;
        end
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    logic loading;
    assign loading = state_reg != ST_STARTUP && state_reg != ST_OPER;
    assign setupReadyOut = 1'b0;
    assign setupReadyOe = state_reg == ST_INIT || state_reg == ST_CLEAR;
    assign doneOut = 1'b0;
    assign doneOe = ~doneRel_reg;
    assign high_during_load = loading;
    assign low_during_load_n = ~loading;
    assign ioConfigMode = ioMode_reg;
    assign userIoTristate = ~ioAct_reg;
    assign cellSetResetHold = ~gsrRel_reg;
    assign internal_bidir_buffer_tristate = ~gsrRel_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_initLow;
        @(posedge clk) disable iff (!rst_n) state_reg == ST_INIT |-> setupReadyOe && doneOe;
    endproperty
    a_initLow: assert property (p_initLow) else $error("init must pull lines low");

    property p_clearZero;
        @(posedge clk) disable iff (!rst_n) state_reg == ST_CLEAR |-> memWe && memWdata == 8'h00;
    endproperty
    a_clearZero: assert property (p_clearZero) else $error("clear must write zero");

    property p_release;
        @(posedge clk) disable iff (!rst_n) $rose(state_reg == ST_WAIT) |-> !setupReadyOe;
    endproperty
    a_release: assert property (p_release) else $error("setup-ready not released");

    property p_readyLen;
        @(posedge clk) disable iff (!rst_n)
            $rose(state_reg == ST_CONFIG) |-> $past(rdyCnt_reg) == (mode_reg[MODE_MASTER_BIT] ? RDY_M : RDY_S);
    endproperty
    a_readyLen: assert property (p_readyLen) else $error("wrong ready wait");

    property p_sampled;
        @(posedge clk) disable iff (!rst_n)
            $rose(state_reg == ST_CONFIG) |-> $past(rdyS, 1) && $past(rdyS, 2) && mode_reg == $past(modeS);
    endproperty
    a_sampled: assert property (p_sampled) else $error("entered config too early");

    property p_countZero;
        @(posedge clk) disable iff (!rst_n) $rose(state_reg == ST_CONFIG) |-> cfgCount_reg == 24'h0;
    endproperty
    a_countZero: assert property (p_countZero) else $error("count not cleared");

    property p_startup;
        @(posedge clk) disable iff (!rst_n)
            $rose(state_reg == ST_STARTUP) |-> $past(cfgCount_reg) == $past(length_reg) && $past(endSeen_reg);
    endproperty
    a_startup: assert property (p_startup) else $error("start-up before load complete");

    property p_abort;
        @(posedge clk) disable iff (!rst_n) state_reg == ST_CONFIG && !rstS |=> state_reg == ST_INIT;
    endproperty
    a_abort: assert property (p_abort) else $error("reset did not abort");

    property p_resetIgnored;
        @(posedge clk) disable iff (!rst_n) state_reg == ST_OPER && prgS |=> state_reg == ST_OPER;
    endproperty
    a_resetIgnored: assert property (p_resetIgnored) else $error("left operation without reprogram");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
            loading |-> userIoTristate && cellSetResetHold && internal_bidir_buffer_tristate && high_during_load;
    endproperty
    a_hold: assert property (p_hold) else $error("outputs not safe while loading");

    property p_syncIo;
        @(posedge clk) disable iff (!rst_n) ctrl_reg.syncStart && $rose(ioAct_reg) |-> $past(doneS);
    endproperty
    a_syncIo: assert property (p_syncIo) else $error("I/O active before DONE high");

    c_oper: cover property (@(posedge clk) disable iff (!rst_n) $rose(state_reg == ST_OPER));
    c_abort: cover property (@(posedge clk) disable iff (!rst_n) state_reg == ST_CONFIG ##1 state_reg == ST_INIT);
    c_reprog: cover property (@(posedge clk) disable iff (!rst_n) state_reg == ST_OPER ##1 state_reg == ST_INIT);

endmodule

/* File: tb/fcss_cfg_source.sv */
`timescale 1ns/1ps
// ************
// Serial source
// ************
module fcss_cfg_source (
    output logic cfgClk,
    output logic cfgData
);
    initial begin
        cfgClk = 1'b0;
        cfgData = 1'b0;
    end
    // MSB-first bytes, kept clear of the sampling edge
    task automatic send_byte(input logic [7:0] b);
        #10;
        for (int i = 7; i >= 0; i--) begin
            cfgData = b[i];
            #200 cfgClk = 1'b1;
            #200 cfgClk = 1'b0;
        end
        // Released line flips so a stale bit is never read
        cfgData = ~cfgData;
    endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin badCount++; $display("Error %0t: mismatch", $time); end end
module testbench;
    import fcss_pkg::*;
    // ************
    // Harness
    // ************
    logic clk = 0, rst_n = 0, avsRead = 0, avsWrite = 0, extHold = 0, prgN = 1, rstReqN = 1;
    logic [3:0] avsAddress = 4'h0, modePins = 4'h4;
    logic [31:0] avsWritedata = 32'h0, avsReaddata, q;
    logic avsWaitrequest, srOe, srOut, dnOe, dnOut, cfg_clock, cDat, hdl, ldlN, ioTri, ffHold, biTri, cOe, cOut;
    logic [2:0] ioMode;
    int badCount = 0, compares = 0;
    always #25 clk = ~clk;
    fcss_cfg_source u_src (.cfgClk(cfg_clock), .cfgData(cDat));
    // Wired-AND lines with pull-ups; extHold is outside logic pulling low
    fpga_config_state_sequencer u_dut (.clk(clk), .rst_n(rst_n), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(4'hF),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .setupReadyIn((srOe ? srOut : 1'b1) & ~extHold), .setupReadyOut(srOut), .setupReadyOe(srOe),
        .doneIn(dnOe ? dnOut : 1'b1), .doneOut(dnOut), .doneOe(dnOe),
        .reprogram_request_n(prgN), .resetRequest_n(rstReqN), .modePins(modePins), .cfg_clock_in(cfg_clock),
        .cfg_clock_out(cOut), .cfg_clock_oe(cOe), .cfgData(cDat), .high_during_load(hdl), .low_during_load_n(ldlN),
        .ioConfigMode(ioMode), .userIoTristate(ioTri), .cellSetResetHold(ffHold),
        .internal_bidir_buffer_tristate(biTri));
    task automatic printVerdict();
        $display("compares %0d badCount %0d", compares, badCount);
        if (badCount == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 20);
        if (avsWaitrequest !== 1'b0) printVerdictFail();
        r = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        // Idle edge, so a next call never re-raises at the release edge
        @(posedge clk);
    endtask
    task automatic printVerdictFail();
        badCount++;
        printVerdict();
    endtask
    task automatic wait_state(input logic [5:0] st);
        int n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0, q);
            n++;
        end while (q[5:0] !== st && n < 150);
        `CHK(q[5:0], st)
        if (q[5:0] !== st) printVerdict();
    endtask
    // ************
    // Scenarios
    // ************
    task automatic t_init();
        `CHK({srOe, dnOe, hdl, ldlN, ioTri, ffHold, biTri}, 7'b1110111)
        bus(1'b0, OFS_LENGTH, 32'h0, q);
        `CHK(q[23:0], LENGTH_RESET)
        // Pins need the synchroniser first, so looked at after one bus cycle
        `CHK(ioMode, 3'h4)
        bus(1'b1, OFS_LENGTH, 32'h0000_0010, q);
    endtask
    task automatic t_hold();
        extHold <= 1'b1;
        repeat (150) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        `CHK(q[5:0], ST_WAIT)
        `CHK(srOe, 1'b0)
        extHold <= 1'b0;
        wait_state(ST_CONFIG);
        `CHK(q[15:12], 4'h4)
        bus(1'b0, OFS_COUNT, 32'h0, q);
        `CHK(q[23:0], 24'h0)
    endtask
    task automatic t_load();
        u_src.send_byte(8'h5A);
        @(posedge clk);
        bus(1'b0, OFS_COUNT, 32'h0, q);
        `CHK(q[23:0], 24'h8)
        `CHK({hdl, ldlN, ffHold, ioTri, biTri}, 5'b10111)
        u_src.send_byte(END_WORD);
        @(posedge clk);
        wait_state(ST_OPER);
        `CHK({dnOe, hdl, ldlN, ioTri, ffHold, biTri}, 6'b001000)
    endtask
    task automatic t_reprog();
        logic v;
        bus(1'b1, OFS_CTRL, 32'h0000_0401, q);
        bus(1'b0, OFS_CTRL, 32'h0, q);
        `CHK(q[10:0], 11'h401)
        rstReqN <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK(dnOe, 1'b0)
        rstReqN <= 1'b1;
        modePins <= 4'h5;
        prgN <= 1'b0;
        repeat (5) @(posedge clk);
        prgN <= 1'b1;
        `CHK({dnOe, ioTri}, 2'b11)
        // Skipped clearing reaches configuration long before a clear walk ends
        repeat (45) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        `CHK(q[5:0], ST_CONFIG)
        `CHK({cOe, ioMode}, 4'b1101)
        v = cOut;
        repeat (4) @(posedge clk);
        `CHK(cOut, ~v)
    endtask
    task automatic t_abort();
        rstReqN <= 1'b0;
        repeat (120) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        `CHK(q[3], 1'b0)
        `CHK(q[5:0], ST_WAIT)
        `CHK(hdl, 1'b1)
        rstReqN <= 1'b1;
        wait_state(ST_CONFIG);
    endtask
    initial begin
        #4000000 printVerdictFail();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_init();
        t_hold();
        t_load();
        t_reprog();
        t_abort();
        printVerdict();
    end
endmodule
